//--- aatsc_pkg.sv
// shared constants and types for the aux converter and temperature sensor control
`default_nettype none
package aatsc_pkg;
  localparam logic [6:0] ADDR_CONV_CFG = 7'h0F;
  localparam logic [6:0] ADDR_BRIDGE_OFS = 7'h10;
  localparam logic [6:0] ADDR_CONV_RESULT = 7'h11;
  localparam logic [6:0] ADDR_TEMP_CTRL = 7'h12;
  localparam logic [6:0] ADDR_TEMP_VOFS = 7'h13;
  localparam logic [7:0] RST_CONV_CFG = 8'h00;
  localparam logic [3:0] RST_BRIDGE_OFS = 4'h0;
  localparam logic [7:0] RST_RESULT = 8'h00;
  localparam logic [7:0] RST_TEMP_CTRL = 8'h20;
  localparam logic [7:0] RST_TEMP_VOFS = 8'h00;
  localparam int CFG_BUSY = 7;
  localparam int CFG_SEL_LSB = 4;
  localparam int CFG_REF_LSB = 2;
  localparam int CFG_GAIN_LSB = 0;
  localparam int TSC_RANGE_LSB = 6;
  localparam int TSC_SHIFT = 5;
  localparam int TSC_TRIM_EN = 4;
  localparam int TSC_TRIM_LSB = 2;
  localparam int TSC_VBG_LSB = 0;
  localparam logic [2:0] SEL_TEMP_SENSOR = 3'h0;
  localparam logic [1:0] REF_BANDGAP = 2'h0;
  localparam logic [1:0] RANGE_ABS_TEST = 2'h2;
  localparam logic [7:0] SAR_FIRST = 8'h80;
  localparam int CLK_PERIOD_NS = 4;
  localparam int CONV_TIME_NS = 350000;
  // longest time: rounded down
  localparam int CONV_CYC = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 17;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } aatsc_state_t;

  typedef struct packed
  {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } aatsc_req_t;

  typedef struct packed
  {
    logic [2:0] in_sel;
    logic [1:0] ref_sel;
    logic [1:0] gain;
    logic [3:0] bridge_ofs;
    logic ts_power_en;
    logic [1:0] ts_range;
    logic temperature_shift_control;
    logic abs_temp_mode;
    logic trim_en;
    logic [1:0] trim;
    logic [1:0] vbg_trim;
    logic [7:0] dac_code;
  } aatsc_ana_t;

  typedef struct packed
  {
    aatsc_state_t st;
    logic [7:0] cfg;
    logic [3:0] bofs;
    logic [7:0] tsc;
    logic [7:0] tvo;
    logic [7:0] result;
    logic [7:0] code;
    logic [7:0] mask;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] sc;
    logic [7:0] rdata;
  } aatsc_regs_t;
endpackage
`default_nettype wire

//--- aatsc_ctrl.sv
// register file, conversion sequencer and sensor controls of the aux converter
`default_nettype none
module aatsc_ctrl
  import aatsc_pkg::*;
#(
  parameter logic [CNT_W-1:0] CONV_CYCLES = CNT_W'(CONV_CYC)
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire aatsc_req_t req,
  input wire logic atb_temp_sel,
  input wire logic cmp_hi,
  output logic [7:0] reg_rdata,
  output logic busy,
  output aatsc_ana_t ana
);
  localparam logic [CNT_W-1:0] STEP_CYCLES = CONV_CYCLES >> 3;

  function automatic logic [7:0] final_result(input logic [7:0] code, input logic [7:0] ofs,
                                              input logic en);
    logic [8:0] sum;
    sum = {1'b0, code} + {1'b0, ofs};
    if (!en)
      return code;
    return sum[8] ? 8'hFF : sum[7:0];
  endfunction

  aatsc_regs_t r;
  aatsc_regs_t n;
  logic start;
  logic wr_cfg;

  always_comb
  begin
    n = r;
    wr_cfg = req.wr && req.addr == ADDR_CONV_CFG;
    start = wr_cfg && req.wdata[CFG_BUSY];
    if (req.wr)
    begin
      case (req.addr)
        ADDR_CONV_CFG: n.cfg[6:0] = req.wdata[6:0];
        ADDR_BRIDGE_OFS: n.bofs = req.wdata[3:0];
        ADDR_TEMP_CTRL: n.tsc = req.wdata;
        ADDR_TEMP_VOFS: n.tvo = req.wdata;
        default: n.bofs = r.bofs;
      endcase
    end
    case (r.st)
      ST_IDLE:
      begin
        if (start)
        begin
          n.st = ST_CONV;
          n.cfg[CFG_BUSY] = 1'b1;
          n.cnt = '0;
          n.sc = '0;
          n.code = SAR_FIRST;
          n.mask = SAR_FIRST;
        end
      end
      ST_CONV:
      begin
        n.cnt = r.cnt + CNT_W'(1);
        n.sc = r.sc + CNT_W'(1);
        if (r.sc == STEP_CYCLES - CNT_W'(1))
        begin
          n.sc = '0;
          if (r.mask != 8'h00)
          begin
            n.code = (cmp_hi ? r.code : (r.code & ~r.mask)) | (r.mask >> 1);
            n.mask = r.mask >> 1;
          end
        end
        if (r.cnt == CONV_CYCLES - CNT_W'(1))
        begin
          n.st = ST_IDLE;
          n.cfg[CFG_BUSY] = 1'b0;
          n.result = final_result(n.code, r.tvo, r.tsc[TSC_SHIFT]);
        end
      end
      default: n.st = ST_IDLE;
    endcase
    if (req.rd)
    begin
      case (req.addr)
        ADDR_CONV_CFG: n.rdata = r.cfg;
        ADDR_BRIDGE_OFS: n.rdata = {4'h0, r.bofs};
        ADDR_CONV_RESULT: n.rdata = r.result;
        ADDR_TEMP_CTRL: n.rdata = r.tsc;
        ADDR_TEMP_VOFS: n.rdata = r.tvo;
        default: n.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      r.st <= ST_IDLE;
      r.cfg <= RST_CONV_CFG;
      r.bofs <= RST_BRIDGE_OFS;
      r.tsc <= RST_TEMP_CTRL;
      r.tvo <= RST_TEMP_VOFS;
      r.result <= RST_RESULT;
      r.code <= 8'h00;
      r.mask <= 8'h00;
      r.cnt <= '0;
      r.sc <= '0;
      r.rdata <= 8'h00;
    end
    else
      r <= n;
  end

  assign reg_rdata = r.rdata;
  assign busy = r.cfg[CFG_BUSY];

  always_comb
  begin
    ana.in_sel = r.cfg[CFG_SEL_LSB +: 3];
    ana.ref_sel = r.cfg[CFG_REF_LSB +: 2];
    ana.gain = r.cfg[CFG_GAIN_LSB +: 2];
    ana.bridge_ofs = r.bofs;
    ana.ts_power_en = r.cfg[CFG_SEL_LSB +: 3] == SEL_TEMP_SENSOR || atb_temp_sel;
    ana.ts_range = r.tsc[TSC_RANGE_LSB +: 2];
    ana.temperature_shift_control = r.tsc[TSC_SHIFT];
    ana.abs_temp_mode = !r.tsc[TSC_SHIFT] && r.tsc[TSC_RANGE_LSB +: 2] == RANGE_ABS_TEST;
    ana.trim_en = r.tsc[TSC_TRIM_EN];
    ana.trim = r.tsc[TSC_TRIM_EN] ? r.tsc[TSC_TRIM_LSB +: 2] : 2'h0;
    ana.vbg_trim = r.tsc[TSC_VBG_LSB +: 2];
    ana.dac_code = r.code;
  end

  logic [CNT_W-1:0] busy_len;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      busy_len <= '0;
    else if (busy)
      busy_len <= busy_len + CNT_W'(1);
    else
      busy_len <= '0;
  end

  sequence s_start_idle;
    r.st == ST_IDLE && wr_cfg && req.wdata[CFG_BUSY];
  endsequence

  sequence s_busy_begins;
    busy && busy_len == '0;
  endsequence

  a_start_sets_busy:
    assert property (@(posedge clock) disable iff (!rst_n) s_start_idle |=> s_busy_begins)
    else $error("start did not raise busy");

  a_busy_exact_len:
    assert property (@(posedge clock) disable iff (!rst_n) $fell(busy) |-> busy_len == CONV_CYCLES)
    else $error("busy length differs from conversion time");

  a_result_held:
    assert property (@(posedge clock) disable iff (!rst_n) busy ##1 busy |-> $stable(r.result))
    else $error("result changed during conversion");

  a_result_final:
    assert property (@(posedge clock) disable iff (!rst_n)
      $fell(busy) && !$past(r.tsc[TSC_SHIFT]) |-> r.result == r.code)
    else $error("result not the converted code");

  a_offset_added:
    assert property (@(posedge clock) disable iff (!rst_n)
      $fell(busy) |-> r.result == final_result(r.code, $past(r.tvo), $past(r.tsc[TSC_SHIFT])))
    else $error("digital offset not applied");

  a_reset_values:
    assert property (@(posedge clock) disable iff (!rst_n)
      !$past(rst_n) |-> r.cfg == RST_CONV_CFG && r.tsc == RST_TEMP_CTRL && !busy)
    else $error("wrong reset values");

  a_cfg_fields:
    assert property (@(posedge clock) disable iff (!rst_n)
      wr_cfg |=> r.cfg[6:0] == $past(req.wdata[6:0]))
    else $error("configuration fields not stored");

  a_bridge_ofs:
    assert property (@(posedge clock) disable iff (!rst_n)
      req.wr && req.addr == ADDR_BRIDGE_OFS |=> ana.bridge_ofs == $past(req.wdata[3:0]))
    else $error("bridge offset not applied");

  a_sensor_power:
    assert property (@(posedge clock) disable iff (!rst_n)
      ana.ts_power_en == (ana.in_sel == SEL_TEMP_SENSOR || atb_temp_sel))
    else $error("sensor power does not follow selection");

  a_abs_mode:
    assert property (@(posedge clock) disable iff (!rst_n)
      ana.abs_temp_mode |-> !ana.temperature_shift_control && ana.ts_range == RANGE_ABS_TEST)
    else $error("absolute mode without its settings");

  a_trim_gate:
    assert property (@(posedge clock) disable iff (!rst_n) !ana.trim_en |-> ana.trim == 2'h0)
    else $error("trim applied while disabled");

  a_sar_mask:
    assert property (@(posedge clock) disable iff (!rst_n) busy |-> $onehot0(r.mask))
    else $error("approximation mask not one-hot");
endmodule // aatsc_ctrl
`default_nettype wire

//--- aatsc_tb.sv
// self-checking bench for the aux converter and temperature sensor control
`default_nettype none
module testbench
  import aatsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NCYC = 64;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  aatsc_req_t req = '0;
  logic atb_temp_sel = 1'b0;
  logic cmp_hi = 1'b0;
  logic [7:0] reg_rdata;
  logic busy;
  aatsc_ana_t ana;
  logic [7:0] vin = 8'h00;
  logic [7:0] last = 8'h00;
  logic rd_d = 1'b0;
  logic [15:0] q[$];
  int error_cnt = 0;
  int tests_run = 0;

  aatsc_ctrl #(.CONV_CYCLES(CNT_W'(NCYC))) i_dut (.clock(clock), .rst_n(rst_n), .req(req),
    .atb_temp_sel(atb_temp_sel), .cmp_hi(cmp_hi), .reg_rdata(reg_rdata), .busy(busy), .ana(ana));

  always #2 clock = ~clock;

  // comparator: high while input at or above trial code
  always @(posedge clock)
  begin
    #1 cmp_hi = (ana.dac_code <= vin);
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // read data lands one cycle after the read strobe
  always @(posedge clock)
  begin
    if (rd_d && q.size() > 0)
    begin
      chk($sformatf("reg %h", q[0][14:8]), q[0][7:0], reg_rdata);
      void'(q.pop_front());
    end
    rd_d <= req.rd;
  end

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(posedge clock);
    #1 req.wr = 1'b0;
    @(posedge clock);
    #1;
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    q.push_back({1'b0, a, e});
    req.rd = 1'b1;
    req.addr = a;
    @(posedge clock);
    #1 req.rd = 1'b0;
    @(posedge clock);
    #1;
  endtask

  task automatic conv(input logic [7:0] v, input logic [7:0] t, input logic off);
    int n;
    logic [8:0] s;
    wr(ADDR_TEMP_VOFS, t);
    wr(ADDR_TEMP_CTRL, {2'b00, off, 5'h00});
    vin = v;
    wr(ADDR_CONV_CFG, 8'h80);
    rd(ADDR_CONV_CFG, 8'h80);
    rd(ADDR_CONV_RESULT, last);
    wr(ADDR_CONV_CFG, 8'h80);
    wr(ADDR_CONV_RESULT, 8'h5a);
    rd(ADDR_CONV_RESULT, last);
    n = 11;
    while (busy === 1'b1 && n < 1000)
    begin
      @(posedge clock);
      #1 n++;
    end
    if (n >= 1000)
    begin
      error_cnt++;
      tally_and_finish();
    end
    else
    begin
      chk("busy cycles", 8'(NCYC), 8'(n));
      s = {1'b0, v} + (off ? {1'b0, t} : 9'h000);
      last = s[8] ? 8'hff : s[7:0];
      rd(ADDR_CONV_RESULT, last);
      rd(ADDR_CONV_CFG, 8'h00);
    end
  endtask

  initial
  begin
    void'($urandom(32'h9e4c_1155));
    repeat (16) @(posedge clock);
    #1 rst_n = 1'b1;
    rd(ADDR_CONV_CFG, RST_CONV_CFG);
    rd(ADDR_BRIDGE_OFS, 8'h00);
    rd(ADDR_CONV_RESULT, RST_RESULT);
    rd(ADDR_TEMP_CTRL, RST_TEMP_CTRL);
    rd(ADDR_TEMP_VOFS, RST_TEMP_VOFS);
    rd(7'h14, 8'h00);
    chk("sensor power", 8'h01, {7'h00, ana.ts_power_en});
    conv(8'hff, 8'h10, 1'b1);
    conv(8'h00, 8'h00, 1'b0);
    repeat (3) conv(8'($urandom), 8'($urandom), 1'($urandom));
    wr(ADDR_BRIDGE_OFS, 8'hff);
    rd(ADDR_BRIDGE_OFS, 8'h0f);
    chk("bridge offset", 8'h0f, {4'h0, ana.bridge_ofs});
    wr(ADDR_CONV_CFG, 8'h7b);
    rd(ADDR_CONV_CFG, 8'h7b);
    chk("cfg fields", 8'h7b, {1'b0, ana.in_sel, ana.ref_sel, ana.gain});
    chk("sensor power", 8'h00, {7'h00, ana.ts_power_en});
    atb_temp_sel = 1'b1;
    @(posedge clock);
    #1 chk("sensor power", 8'h01, {7'h00, ana.ts_power_en});
    atb_temp_sel = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_TEMP_CTRL, {2'(i), 6'h20});
      chk("range", {5'h00, 2'(i), 1'b0}, {5'h00, ana.ts_range, ana.abs_temp_mode});
    end
    wr(ADDR_TEMP_CTRL, 8'h9c);
    chk("temp ctl", 8'h4f, {1'b0, ana.ts_range, ana.temperature_shift_control, ana.abs_temp_mode,
      ana.trim_en, ana.trim});
    wr(ADDR_TEMP_CTRL, 8'h6e);
    chk("temp ctl", 8'h30, {1'b0, ana.ts_range, ana.temperature_shift_control, ana.abs_temp_mode,
      ana.trim_en, ana.trim});
    chk("vbg trim", 8'h02, {6'h00, ana.vbg_trim});
    rd(ADDR_TEMP_CTRL, 8'h6e);
    repeat (2) @(posedge clock);
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
